// ### inc/acx_pkg.sv
// acx_pkg: shared constants for the accumulator / coordinate command executor.
// assumes one 10 MHz system clock; nothing here holds logic.
package acx_pkg;
    // ----------------------------------------------------------------
    // frame layout
    // ----------------------------------------------------------------
    localparam logic [3:0] FRAME_LEN = 4'h9;   // bytes per command frame
    localparam logic [3:0] POS_ADDR = 4'h0;    // target address byte
    localparam logic [3:0] POS_INSTR = 4'h1;   // instruction byte
    localparam logic [3:0] POS_TYPE = 4'h2;    // type byte
    localparam logic [3:0] POS_BANK = 4'h3;    // motor/bank byte
    localparam logic [3:0] POS_SUM = 4'h8;     // checksum byte
    // ----------------------------------------------------------------
    // instruction codes
    // ----------------------------------------------------------------
    localparam logic [7:0] CAPTURE_POSITION_CMD = 8'h20;
    localparam logic [7:0] XREG_CALCULATE_CMD = 8'h21;
    localparam logic [7:0] ACCU_TO_AXIS_PARAM_CMD = 8'h22;
    localparam logic [7:0] ACCU_TO_GLOBAL_PARAM_CMD = 8'h23;
    localparam logic [7:0] ACCU_TO_COORDINATE_CMD = 8'h27;
    // ----------------------------------------------------------------
    // x-register operation types
    // ----------------------------------------------------------------
    localparam logic [7:0] OP_ADD = 8'h00;
    localparam logic [7:0] OP_SUB = 8'h01;
    localparam logic [7:0] OP_MUL = 8'h02;
    localparam logic [7:0] OP_DIV = 8'h03;
    localparam logic [7:0] REMAINDER_OP = 8'h04;
    localparam logic [7:0] OP_AND = 8'h05;
    localparam logic [7:0] OP_OR = 8'h06;
    localparam logic [7:0] OP_XOR = 8'h07;
    localparam logic [7:0] OP_NOT = 8'h08;
    localparam logic [7:0] OP_LOAD = 8'h09;
    localparam logic [7:0] OP_SWAP = 8'h0a;
    // ----------------------------------------------------------------
    // reply status codes
    // ----------------------------------------------------------------
    localparam logic [7:0] ST_OK = 8'h64;
    localparam logic [7:0] ST_BAD_SUM = 8'h01;
    localparam logic [7:0] ST_BAD_CMD = 8'h02;
    localparam logic [7:0] ST_BAD_VAL = 8'h04;
    // ----------------------------------------------------------------
    // coordinates and global parameters
    // ----------------------------------------------------------------
    localparam logic [4:0] COORD_MAX = 5'h14;       // highest coordinate entry
    localparam logic [7:0] GP_PERSIST = 8'h54;      // persistence global parameter
    localparam logic [7:0] BANK_GP_MAIN = 8'h00;
    localparam logic [7:0] BANK_GP_USER = 8'h02;
    localparam logic [7:0] BANK_GP_IRQ = 8'h03;
    localparam logic [31:0] ACC_RST = 32'h0000_0000;
    localparam logic PERSIST_RST = 1'b0;            // default keeps coordinates in ram
    // ----------------------------------------------------------------
    // executor states, one-hot
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        ACX_RECV = 2'b01,
        ACX_EXEC = 2'b10
    } acx_state_t;
endpackage : acx_pkg

// ### rtl/acx_executor.sv
// acx_executor: takes nine-byte command frames and runs the accumulator,
// x-register and coordinate commands, answering each frame addressed to own_addr with a reply.
// assumes bytes and side inputs are synchronous to clk_sys; parameter stores
// and the nonvolatile store sit outside and take the write pulses.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - code 39 writes accumulator into chosen coordinate
// - global parameter 84 selects ram or nonvolatile
// - coordinate zero never saved nor restored
// - code 20 hex captures actual position
// - code 33 types 0-4 do arithmetic
// - types 5-7 and/or/xor, 8 inverts x
// - type 9 loads x, 10 swaps
// - code 34 writes axis parameter, motor 0
// - code 35 writes global parameter, bank 0/2/3
// - direct mode reply carries status 100
module acx_executor
    import acx_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [7:0] own_addr,           // module target address
    input wire logic rx_valid,                 // frame byte offered
    input wire logic [7:0] rx_byte,
    output logic rx_ready,                     // byte taken when high
    input wire logic acc_load_valid,           // accumulator load from a parameter read
    input wire logic [31:0] acc_load_data,
    input wire logic [31:0] actual_pos,        // present position of motor 0
    input wire logic nv_restore_valid,         // startup restore of one coordinate
    input wire logic [4:0] nv_restore_idx,
    input wire logic [31:0] nv_restore_data,
    input wire logic [4:0] coord_rd_idx,
    output logic [31:0] coord_rd_data,
    output logic reply_valid,
    output logic [7:0] reply_status,
    output logic [31:0] reply_value,
    output logic axis_wr_valid,
    output logic glob_wr_valid,
    output logic [7:0] param_num,
    output logic [7:0] param_bank,
    output logic [31:0] param_data,
    output logic nv_save_valid,
    output logic [4:0] nv_save_idx,
    output logic [31:0] nv_save_data,
    output logic [31:0] acc_out,
    output logic [31:0] xreg_out,
    output logic persist_out
);
    // ----------------------------------------------------------------
    // state and storage
    // ----------------------------------------------------------------
    acx_state_t state_reg;                     // receive or execute
    logic [3:0] cnt_reg;                       // byte position in frame
    logic [7:0] sum_reg;                       // running checksum
    logic [7:0] addr_reg, instr_reg, type_reg, bank_reg;
    logic sum_ok_reg;                          // checksum matched
    logic [31:0] acc_reg, acc_next;            // accumulator
    logic [31:0] x_reg, x_next;                // x register
    logic persist_reg;                         // coordinates also kept in nv store
    logic [31:0] coord_mem [0:20];             // coordinate array, motor 0

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    wire take_byte = rx_valid && (state_reg == ACX_RECV);
    wire last_byte = take_byte && (cnt_reg == POS_SUM);
    wire for_me = (addr_reg == own_addr);
    wire coord_ok = (type_reg[7:5] == 3'h0) && (type_reg[4:0] <= COORD_MAX);
    wire motor_ok = (bank_reg == 8'h00);
    wire bank_ok = (bank_reg == BANK_GP_MAIN) || (bank_reg == BANK_GP_USER)
                || (bank_reg == BANK_GP_IRQ);
    wire is_aco = (instr_reg == ACCU_TO_COORDINATE_CMD);
    wire is_cco = (instr_reg == CAPTURE_POSITION_CMD);
    wire is_calc = (instr_reg == XREG_CALCULATE_CMD);
    wire is_aap = (instr_reg == ACCU_TO_AXIS_PARAM_CMD);
    wire is_agp = (instr_reg == ACCU_TO_GLOBAL_PARAM_CMD);
    wire known = is_aco || is_cco || is_calc || is_aap || is_agp;
    wire div_zero = (x_reg == 32'h0000_0000)
                 && ((type_reg == OP_DIV) || (type_reg == REMAINDER_OP));
    wire args_ok = ((is_aco || is_cco) && coord_ok && motor_ok)
                || (is_calc && (type_reg <= OP_SWAP) && !div_zero)
                || (is_aap && motor_ok)
                || (is_agp && bank_ok);
    wire exec = (state_reg == ACX_EXEC) && for_me;
    wire run = exec && sum_ok_reg && known && args_ok;
    wire coord_wr = run && (is_aco || is_cco);
    wire [31:0] coord_val = is_cco ? actual_pos : acc_reg;
    wire persist_wr = run && is_agp && (type_reg == GP_PERSIST)
                   && (bank_reg == BANK_GP_MAIN);
    wire restore_ok = nv_restore_valid && (nv_restore_idx != 5'h00)
                   && (nv_restore_idx <= COORD_MAX);
    wire [7:0] status_w = !sum_ok_reg ? ST_BAD_SUM :
                          !known ? ST_BAD_CMD :
                          !args_ok ? ST_BAD_VAL : ST_OK;

    assign rx_ready = (state_reg == ACX_RECV);
    assign acc_out = acc_reg;
    assign xreg_out = x_reg;
    assign persist_out = persist_reg;

    // ----------------------------------------------------------------
    // x-register calculation
    // ----------------------------------------------------------------
    // division results truncate toward zero, remainder takes the dividend sign
    always_comb begin
        acc_next = acc_reg;
        x_next = x_reg;
        if (run && is_calc) begin
            case (type_reg)
                OP_ADD: acc_next = acc_reg + x_reg;
                OP_SUB: acc_next = acc_reg - x_reg;
                OP_MUL: acc_next = 32'($signed(acc_reg) * $signed(x_reg));
                OP_DIV: acc_next = 32'($signed(acc_reg) / $signed(x_reg));
                REMAINDER_OP: acc_next = 32'($signed(acc_reg) % $signed(x_reg));
                OP_AND: acc_next = acc_reg & x_reg;
                OP_OR: acc_next = acc_reg | x_reg;
                OP_XOR: acc_next = acc_reg ^ x_reg;
                OP_NOT: x_next = ~x_reg;
                OP_LOAD: x_next = acc_reg;
                OP_SWAP: begin
                    acc_next = x_reg;
                    x_next = acc_reg;
                end
                default: acc_next = acc_reg;
            endcase
        end else if (acc_load_valid) begin
            // the sender loads the accumulator ahead of a transfer
            acc_next = acc_load_data;
        end
    end

    // ----------------------------------------------------------------
    // frame receiver and state
    // ----------------------------------------------------------------
    // nine bytes, the last must equal the low byte of the sum of the rest
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= ACX_RECV;
            cnt_reg <= 4'h0;
            sum_reg <= 8'h00;
            sum_ok_reg <= 1'b0;
        end else if (state_reg == ACX_EXEC) begin
            state_reg <= ACX_RECV;
            cnt_reg <= 4'h0;
            sum_reg <= 8'h00;
        end else if (take_byte) begin
            cnt_reg <= last_byte ? 4'h0 : cnt_reg + 4'h1;
            sum_reg <= sum_reg + rx_byte;
            if (last_byte) begin
                sum_ok_reg <= (sum_reg == rx_byte);
                state_reg <= ACX_EXEC;
            end
        end
    end

    // header fields kept for execution
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            addr_reg <= 8'h00;
            instr_reg <= 8'h00;
            type_reg <= 8'h00;
            bank_reg <= 8'h00;
        end else if (take_byte) begin
            if (cnt_reg == POS_ADDR) addr_reg <= rx_byte;
            if (cnt_reg == POS_INSTR) instr_reg <= rx_byte;
            if (cnt_reg == POS_TYPE) type_reg <= rx_byte;
            if (cnt_reg == POS_BANK) bank_reg <= rx_byte;
        end
    end

    // ----------------------------------------------------------------
    // registers of the command set
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            acc_reg <= ACC_RST;
            x_reg <= ACC_RST;
            persist_reg <= PERSIST_RST;
        end else begin
            acc_reg <= acc_next;
            x_reg <= x_next;
            if (persist_wr) persist_reg <= (acc_reg != 32'h0000_0000);
        end
    end

    // coordinate array, restore from nv store and command writes
    always_ff @(posedge clk_sys) begin
        if (coord_wr) coord_mem[type_reg[4:0]] <= coord_val;
        else if (restore_ok) coord_mem[nv_restore_idx] <= nv_restore_data;
        coord_rd_data <= (coord_rd_idx <= COORD_MAX) ? coord_mem[coord_rd_idx] : 32'h0;
    end

    // ----------------------------------------------------------------
    // reply and write pulses
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            reply_valid <= 1'b0;
            reply_status <= 8'h00;
            reply_value <= 32'h0;
            axis_wr_valid <= 1'b0;
            glob_wr_valid <= 1'b0;
            param_num <= 8'h00;
            param_bank <= 8'h00;
            param_data <= 32'h0;
            nv_save_valid <= 1'b0;
            nv_save_idx <= 5'h00;
            nv_save_data <= 32'h0;
        end else begin
            reply_valid <= exec;
            reply_status <= exec ? status_w : reply_status;
            reply_value <= 32'h0;
            axis_wr_valid <= run && is_aap;
            glob_wr_valid <= run && is_agp;
            if (run) begin
                param_num <= type_reg;
                param_bank <= bank_reg;
                param_data <= acc_reg;
            end
            // entry zero stays in ram whatever the setting
            nv_save_valid <= coord_wr && persist_reg && (type_reg[4:0] != 5'h00);
            if (coord_wr) begin
                nv_save_idx <= type_reg[4:0];
                nv_save_data <= coord_val;
            end
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    reply_after_frame_a: assert property (
        last_byte && (cnt_reg == POS_SUM) ##1 for_me |=> reply_valid)
        else $error("frame for this address got no reply");
    bad_sum_status_a: assert property (
        exec && !sum_ok_reg |=> reply_status == ST_BAD_SUM && !axis_wr_valid)
        else $error("bad checksum not refused");
    ok_status_a: assert property (
        run |=> reply_valid && reply_status == ST_OK)
        else $error("executed command did not answer ok");
    coord_copy_a: assert property (
        run && is_aco && (coord_rd_idx == type_reg[4:0]) ##1 coord_rd_idx == $past(coord_rd_idx)
        |=> coord_rd_data == $past(acc_reg, 2))
        else $error("accumulator not in coordinate");
    capture_pos_a: assert property (
        run && is_cco && (coord_rd_idx == type_reg[4:0]) ##1 coord_rd_idx == $past(coord_rd_idx)
        |=> coord_rd_data == $past(actual_pos, 2))
        else $error("position not captured");
    calc_add_a: assert property (
        run && is_calc && type_reg == OP_ADD |=> acc_reg == $past(acc_reg) + $past(x_reg))
        else $error("add result wrong");
    calc_logic_a: assert property (
        run && is_calc && type_reg == OP_XOR |=> acc_reg == ($past(acc_reg) ^ $past(x_reg)))
        else $error("xor result wrong");
    calc_swap_a: assert property (
        run && is_calc && type_reg == OP_SWAP
        |=> acc_reg == $past(x_reg) && x_reg == $past(acc_reg))
        else $error("swap wrong");
    axis_write_a: assert property (
        axis_wr_valid |-> param_bank == 8'h00 && param_data == $past(acc_reg))
        else $error("axis write with wrong motor or data");
    glob_bank_a: assert property (
        glob_wr_valid |-> param_bank == BANK_GP_MAIN || param_bank == BANK_GP_USER
        || param_bank == BANK_GP_IRQ)
        else $error("global write to bad bank");
    no_save_zero_a: assert property (
        nv_save_valid |-> nv_save_idx != 5'h00 && $past(persist_reg))
        else $error("nv save of entry zero or with ram-only setting");

    cover_aco_c: cover property (run && is_aco);
    cover_calc_c: cover property (run && is_calc && type_reg == REMAINDER_OP);
    cover_agp_c: cover property (persist_wr ##[1:40] nv_save_valid);
    cover_bad_c: cover property (exec && !sum_ok_reg);
endmodule : acx_executor
`default_nettype wire

// ### dv/acx_host_model.sv
// acx_host_model: host side that offers nine-byte command frames.
// assumes the executor takes a byte on a rising edge while rx_ready is high.
`timescale 1ns/1ps
`default_nettype none
module acx_host_model (
    input wire logic clk_sys,
    input wire logic rx_ready,
    output logic rx_valid,
    output logic [7:0] rx_byte
);
    logic [7:0] fb [0:8]; // bytes of the frame in flight
    logic rdy; // ready seen before the taking edge
    initial begin
        rx_valid = 1'b0;
        rx_byte = 8'h5a;
    end
    // idle byte lane changes mid-cycle so no stale byte lingers
    always @(negedge clk_sys) begin
        if (!rx_valid) begin
            rx_byte <= ~rx_byte;
        end
    end
    // offer one frame, holding each byte until it is taken
    task automatic send_frame(input logic [7:0] adr, input logic [7:0] ins,
                              input logic [7:0] typ, input logic [7:0] bnk,
                              input logic bad);
        logic [7:0] sum;
        int i;
        fb[0] = adr;
        fb[1] = ins;
        fb[2] = typ;
        fb[3] = bnk;
        for (i = 4; i < 8; i++) begin
            fb[i] = 8'h00; // value bytes, msb first, unused here
        end
        sum = 8'h00;
        for (i = 0; i < 8; i++) begin
            sum = sum + fb[i];
        end
        fb[8] = bad ? ~sum : sum; // corrupt only on request
        for (i = 0; i < 9; i++) begin
            rx_valid = 1'b1;
            rx_byte = fb[i];
            rdy = 1'b0;
            while (!rdy) begin
                @(negedge clk_sys);
                rdy = (rx_ready === 1'b1);
                @(posedge clk_sys);
                #1;
            end
        end
        rx_valid = 1'b0;
        rx_byte = ~fb[8];
    endtask : send_frame
endmodule : acx_host_model
`default_nettype wire

// ### dv/acx_executor_test.sv
// acx_executor_test: self-checking bench of the command executor.
// assumes acx_pkg and the host model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module acx_executor_test;
    import acx_pkg::*;
    logic clk_sys = 1'b0; // 10 MHz system clock
    logic rst_b = 1'b0; // active low reset
    logic rx_valid, rx_ready, acc_load_valid, nv_restore_valid, reply_valid;
    logic axis_wr_valid, glob_wr_valid, nv_save_valid, persist_out;
    logic [7:0] rx_byte, reply_status, param_num, param_bank;
    logic [4:0] nv_restore_idx, coord_rd_idx, nv_save_idx;
    logic [31:0] acc_load_data, actual_pos, nv_restore_data, coord_rd_data;
    logic [31:0] reply_value, param_data, nv_save_data, acc_out, xreg_out;
    logic got_rep, got_ax, got_gl, got_nv; // seen in the reply cycle
    logic [31:0] ea, ex; // expected accumulator and x register
    int n_mismatch = 0;
    int total_checks = 0;
    int cycles = 0;
    always #50 clk_sys = ~clk_sys;
    acx_executor acx_executor_inst (.clk_sys(clk_sys), .rst_b(rst_b), .own_addr(8'h01),
        .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_ready(rx_ready),
        .acc_load_valid(acc_load_valid), .acc_load_data(acc_load_data),
        .actual_pos(actual_pos), .nv_restore_valid(nv_restore_valid),
        .nv_restore_idx(nv_restore_idx), .nv_restore_data(nv_restore_data),
        .coord_rd_idx(coord_rd_idx), .coord_rd_data(coord_rd_data),
        .reply_valid(reply_valid), .reply_status(reply_status), .reply_value(reply_value),
        .axis_wr_valid(axis_wr_valid), .glob_wr_valid(glob_wr_valid),
        .param_num(param_num), .param_bank(param_bank), .param_data(param_data),
        .nv_save_valid(nv_save_valid), .nv_save_idx(nv_save_idx),
        .nv_save_data(nv_save_data), .acc_out(acc_out), .xreg_out(xreg_out),
        .persist_out(persist_out));
    acx_host_model acx_host_model_inst (.clk_sys(clk_sys), .rx_ready(rx_ready),
        .rx_valid(rx_valid), .rx_byte(rx_byte));
    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic print_verdict();
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : print_verdict
    // wide enough for the widest packed comparison, so no flag bit is cut off
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        total_checks++;
        if (got !== exp) begin
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
            n_mismatch++;
        end
    endtask : chk
    // send a frame and catch the reply cycle with its pulses
    task automatic cmd(input logic [7:0] adr, input logic [7:0] ins,
                       input logic [7:0] typ, input logic [7:0] bnk, input logic bad);
        @(posedge clk_sys);
        #1;
        acx_host_model_inst.send_frame(adr, ins, typ, bnk, bad);
        {got_rep, got_ax, got_gl, got_nv} = 4'h0;
        for (int i = 0; i < 6 && !got_rep; i++) begin
            @(negedge clk_sys);
            if (reply_valid === 1'b1) begin
                {got_rep, got_ax, got_gl, got_nv} =
                    {1'b1, axis_wr_valid, glob_wr_valid, nv_save_valid};
            end
        end
    endtask : cmd
    task automatic set_acc(input logic [31:0] v);
        @(posedge clk_sys);
        #1;
        acc_load_valid = 1'b1;
        acc_load_data = v;
        @(posedge clk_sys);
        #1;
        acc_load_valid = 1'b0;
    endtask : set_acc
    task automatic rd_coord(input logic [4:0] idx, input logic [31:0] exp);
        @(posedge clk_sys);
        #1;
        coord_rd_idx = idx;
        @(posedge clk_sys);
        #1;
        chk(coord_rd_data, exp);
    endtask : rd_coord
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    // every calculation type against a negative accumulator
    task automatic t_calc();
        logic [31:0] a, x;
        a = 32'hffff_ff9c;
        x = 32'h0000_0007;
        for (int t = 0; t <= 10; t++) begin
            set_acc(x);
            cmd(8'h01, XREG_CALCULATE_CMD, OP_LOAD, 8'h00, 1'b0);
            set_acc(a);
            cmd(8'h01, XREG_CALCULATE_CMD, 8'(t), 8'h00, 1'b0);
            ea = a;
            ex = x;
            case (t)
                0: ea = a + x;
                1: ea = a - x;
                2: ea = a * x;
                3: ea = $signed(a) / $signed(x);
                4: ea = $signed(a) % $signed(x);
                5: ea = a & x;
                6: ea = a | x;
                7: ea = a ^ x;
                8: ex = ~x;
                9: ex = a;
                default: begin
                    ea = x;
                    ex = a;
                end
            endcase
            chk(acc_out, ea);
            chk(xreg_out, ex);
            chk({got_rep, reply_status, reply_value}, {1'b1, ST_OK, 32'h0});
        end
    endtask : t_calc
    // copy and capture into ram-only coordinates
    task automatic t_coord();
        set_acc(32'h1234_5678);
        cmd(8'h01, ACCU_TO_COORDINATE_CMD, 8'h03, 8'h00, 1'b0);
        chk({got_nv, reply_status}, {1'b0, ST_OK});
        rd_coord(5'h03, 32'h1234_5678);
        actual_pos = 32'hfedc_0042;
        cmd(8'h01, CAPTURE_POSITION_CMD, 8'h05, 8'h00, 1'b0);
        rd_coord(5'h05, 32'hfedc_0042);
        cmd(8'h01, ACCU_TO_COORDINATE_CMD, 8'h00, 8'h00, 1'b0);
        @(posedge clk_sys);
        #1;
        {nv_restore_valid, nv_restore_idx, nv_restore_data} = {1'b1, 5'h00, 32'h0bad_0bad};
        @(posedge clk_sys);
        #1;
        nv_restore_valid = 1'b0;
        rd_coord(5'h00, 32'h1234_5678);
    endtask : t_coord
    // parameter transfers with legal and illegal motor and bank fields
    task automatic t_param();
        set_acc(32'h0000_a5c3);
        cmd(8'h01, ACCU_TO_AXIS_PARAM_CMD, 8'h04, 8'h00, 1'b0);
        chk({got_ax, param_num, param_data}, {1'b1, 8'h04, 32'h0000_a5c3});
        cmd(8'h01, ACCU_TO_AXIS_PARAM_CMD, 8'h04, 8'h01, 1'b0);
        chk({got_ax, reply_status}, {1'b0, ST_BAD_VAL});
        for (int b = 0; b < 4; b++) begin
            cmd(8'h01, ACCU_TO_GLOBAL_PARAM_CMD, 8'h2a, 8'(b), 1'b0);
            if (b == 1) begin
                chk({got_gl, reply_status}, {1'b0, ST_BAD_VAL});
            end else begin
                chk({got_gl, param_bank, param_num}, {1'b1, 8'(b), 8'h2a});
            end
        end
    endtask : t_param
    // persistence on: saves for entries above zero, restore lands
    task automatic t_persist();
        set_acc(32'h0000_0001);
        cmd(8'h01, ACCU_TO_GLOBAL_PARAM_CMD, GP_PERSIST, BANK_GP_MAIN, 1'b0);
        chk(persist_out, 32'h1);
        set_acc(32'h0055_aa00);
        cmd(8'h01, ACCU_TO_COORDINATE_CMD, 8'h02, 8'h00, 1'b0);
        chk({got_nv, nv_save_idx, nv_save_data}, {1'b1, 5'h02, 32'h0055_aa00});
        cmd(8'h01, ACCU_TO_COORDINATE_CMD, 8'h00, 8'h00, 1'b0);
        chk(got_nv, 32'h0);
        @(posedge clk_sys);
        #1;
        {nv_restore_valid, nv_restore_idx, nv_restore_data} = {1'b1, 5'h04, 32'h7777_1111};
        @(posedge clk_sys);
        #1;
        nv_restore_valid = 1'b0;
        rd_coord(5'h04, 32'h7777_1111);
    endtask : t_persist
    // broken frames change nothing
    task automatic t_frame();
        cmd(8'h01, XREG_CALCULATE_CMD, OP_NOT, 8'h00, 1'b1);
        chk({reply_status, xreg_out}, {ST_BAD_SUM, ex});
        cmd(8'h02, XREG_CALCULATE_CMD, OP_NOT, 8'h00, 1'b0);
        chk({got_rep, xreg_out}, {1'b0, ex});
        // coordinate entry beyond the array is refused and reads as zero
        cmd(8'h01, ACCU_TO_COORDINATE_CMD, 8'h15, 8'h00, 1'b0);
        chk({got_rep, got_nv, reply_status}, {2'b10, ST_BAD_VAL});
        rd_coord(5'h15, 32'h0);
        // unknown instruction answers with its own status and a zero value
        cmd(8'h01, 8'h24, 8'h00, 8'h00, 1'b0);
        chk({got_rep, reply_status, reply_value}, {1'b1, ST_BAD_CMD, 32'h0});
        // division by a zero x register is refused, accumulator kept
        set_acc(32'h0);
        cmd(8'h01, XREG_CALCULATE_CMD, OP_LOAD, 8'h00, 1'b0);
        set_acc(32'h0000_0063);
        cmd(8'h01, XREG_CALCULATE_CMD, OP_DIV, 8'h00, 1'b0);
        chk({got_rep, reply_status, acc_out}, {1'b1, ST_BAD_VAL, 32'h0000_0063});
    endtask : t_frame
    // ----------------------------------------------------------------
    // main sequence and hang guard
    // ----------------------------------------------------------------
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles >= 8000) begin
            n_mismatch++;
            print_verdict();
        end
    end
    initial begin
        {acc_load_valid, nv_restore_valid} = 2'b00;
        {acc_load_data, actual_pos, nv_restore_data} = {3{32'h0}};
        {nv_restore_idx, coord_rd_idx} = 10'h000;
        repeat (6) @(posedge clk_sys);
        #1;
        chk({rx_ready, reply_valid, acc_out, persist_out}, {2'b10, 32'h0, 1'b0});
        rst_b = 1'b1;
        t_calc();
        t_coord();
        t_param();
        t_persist();
        t_frame();
        print_verdict();
    end
endmodule : acx_executor_test
`default_nettype wire
